// *** rtl/plsc_pkg.sv ***
// Package for the link control, link status and slot capability registers.
// Assumes a 32-bit AXI4-Lite register bus on one core clock.
package plsc_pkg;

  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [7:0] LINK_CTRL_STAT_OFS = 8'hC0;
  localparam logic [7:0] SLOT_CAP_OFS       = 8'hC4;

  // ----------------------------------------
  // Link control field positions
  // ----------------------------------------
  localparam int PM_CTRL_LSB     = 0;
  localparam int RCB_BIT         = 3;
  localparam int LINK_DIS_BIT    = 4;
  localparam int RETRAIN_BIT     = 5;
  localparam int COMMON_CLK_BIT  = 6;
  localparam int EXT_SYNC_BIT    = 7;

  // ----------------------------------------
  // Link status field positions
  // ----------------------------------------
  localparam int SPEED_LSB       = 16;
  localparam int WIDTH_LSB       = 20;
  localparam int TRAIN_ERR_BIT   = 26;
  localparam int TRAINING_BIT    = 27;
  localparam int SLOT_CLK_BIT    = 28;

  // ----------------------------------------
  // Slot capability field positions
  // ----------------------------------------
  localparam int ATTN_BTN_BIT    = 0;
  localparam int LATCH_SENS_BIT  = 2;
  localparam int ATTN_IND_BIT    = 3;
  localparam int PWR_IND_BIT     = 4;
  localparam int HP_CAPABLE_BIT  = 6;

  // ----------------------------------------
  // Reset values and codes
  // ----------------------------------------
  localparam logic [1:0] PM_CTRL_RST    = 2'h0;
  localparam logic [3:0] SPEED_2G5      = 4'h1;
  localparam logic [5:0] WIDTH_X1       = 6'h01;
  localparam logic       SLOT_CLK_RST   = 1'b1;

  // ----------------------------------------
  // AXI responses
  // ----------------------------------------
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Writable link control fields
  typedef struct packed {
    logic       ext_sync;
    logic       common_clk;
    logic       retrain;
    logic       link_dis;
    logic [1:0] pm_ctrl;
  } plsc_lctl_t;

  // Link status sampled from the core
  typedef struct packed {
    logic       slot_clk;
    logic       training;
    logic       train_err;
    logic [5:0] width;
    logic [3:0] speed;
  } plsc_lsts_t;

endpackage

// *** rtl/plsc_sync.sv ***
// Three-stage synchroniser for an input from outside the clock domain.
// The output changes once the second and third stages agree.
`timescale 1ns/1ns
module plsc_sync
  #(parameter int W = 1)
  (
  // Clock and reset
  input  wire logic         aclk,
  input  wire logic         aresetn,
  // Data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
  );

  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end
    else
    begin
      s1_r <= d;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // Filter glitches: accept only a settled value
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      q <= '0;
    else if (s2_r == s3_r)
      q <= s3_r;
  end

endmodule

// *** rtl/plsc_regs.sv ***
// Link control, link status and slot capability registers over AXI4-Lite.
// Assumes mode and hot-plug strap pins are static levels from outside.
`timescale 1ns/1ns
module plsc_regs
  import plsc_pkg::*;
  (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address and data
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Straps and link state from pins
  input  wire logic        reverse_mode,
  input  wire logic        hotplug_strap,
  input  wire logic [3:0]  link_speed_in,
  input  wire logic [5:0]  link_width_in,
  input  wire logic        link_train_err_in,
  input  wire logic        link_training_in,
  // Link controls to the core
  output logic [1:0]       pm_ctrl,
  output logic             link_disable,
  output logic             retrain_link
  );

  // ----------------------------------------
  // Input synchronisation
  // ----------------------------------------
  logic [13:0] pins_s;
  logic        rev_s;
  logic        hp_s;
  plsc_lsts_t  lsts_s;

  plsc_sync #(.W(14)) u_sync
  (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       ({reverse_mode, hotplug_strap, link_speed_in, link_width_in,
                link_train_err_in, link_training_in}),
    .q       (pins_s)
  );

  assign rev_s           = pins_s[13];
  assign hp_s            = pins_s[12];
  assign lsts_s.slot_clk = SLOT_CLK_RST;
  assign lsts_s.training = pins_s[0];
  assign lsts_s.train_err = pins_s[1];
  assign lsts_s.width    = pins_s[7:2];
  assign lsts_s.speed    = pins_s[11:8];

  // Status register: reset to 2.5Gb/s, one lane
  plsc_lsts_t lsts_r;
  logic       sts_valid_r;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      lsts_r      <= '{slot_clk: SLOT_CLK_RST, training: 1'b0, train_err: 1'b0,
                       width: WIDTH_X1, speed: SPEED_2G5};
      sts_valid_r <= 1'b0;
    end
    else
    begin
      // Hold reset values until synchroniser has filled
      sts_valid_r <= 1'b1;
      if (sts_valid_r && lsts_s.speed != 4'h0 && lsts_s.width != 6'h00)
        lsts_r <= lsts_s;
    end
  end

  // ----------------------------------------
  // Write channel
  // ----------------------------------------
  logic        aw_held_r;
  logic        w_held_r;
  logic [7:0]  awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;
  logic        do_write;

  assign do_write = aw_held_r && w_held_r && !s_axi_bvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_r     <= 1'b0;
      w_held_r      <= 1'b0;
      awaddr_r      <= 8'h00;
      wdata_r       <= 32'h0000_0000;
      wstrb_r       <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end
    else
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      if (s_axi_awvalid && !aw_held_r && !s_axi_awready)
      begin
        aw_held_r     <= 1'b1;
        awaddr_r      <= s_axi_awaddr;
        s_axi_awready <= 1'b1;
      end
      if (s_axi_wvalid && !w_held_r && !s_axi_wready)
      begin
        w_held_r     <= 1'b1;
        wdata_r      <= s_axi_wdata;
        wstrb_r      <= s_axi_wstrb;
        s_axi_wready <= 1'b1;
      end
      if (do_write)
      begin
        aw_held_r <= 1'b0;
        w_held_r  <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end
    else if (do_write)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (awaddr_r[7:2] == LINK_CTRL_STAT_OFS[7:2] ||
                       awaddr_r[7:2] == SLOT_CAP_OFS[7:2]) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // ----------------------------------------
  // Link control register
  // ----------------------------------------
  plsc_lctl_t lctl_r;
  logic       ctl_wr;

  assign ctl_wr = do_write && awaddr_r[7:2] == LINK_CTRL_STAT_OFS[7:2] && wstrb_r[0];

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      lctl_r.pm_ctrl    <= PM_CTRL_RST;
      lctl_r.common_clk <= 1'b0;
      lctl_r.ext_sync   <= 1'b0;
    end
    else if (ctl_wr)
    begin
      lctl_r.pm_ctrl    <= wdata_r[PM_CTRL_LSB +: 2];
      lctl_r.common_clk <= wdata_r[COMMON_CLK_BIT];
      lctl_r.ext_sync   <= wdata_r[EXT_SYNC_BIT];
    end
  end

  // Reverse-only writable bits
  // Forward mode forces them back to zero so a mode change leaves no stale control
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      lctl_r.link_dis <= 1'b0;
      lctl_r.retrain  <= 1'b0;
    end
    else if (!rev_s)
    begin
      lctl_r.link_dis <= 1'b0;
      lctl_r.retrain  <= 1'b0;
    end
    else if (ctl_wr)
    begin
      lctl_r.link_dis <= wdata_r[LINK_DIS_BIT];
      lctl_r.retrain  <= wdata_r[RETRAIN_BIT];
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pm_ctrl      <= PM_CTRL_RST;
      link_disable <= 1'b0;
      retrain_link <= 1'b0;
    end
    else
    begin
      pm_ctrl      <= lctl_r.pm_ctrl;
      link_disable <= lctl_r.link_dis;
      retrain_link <= lctl_r.retrain;
    end
  end

  // ----------------------------------------
  // Read channel
  // ----------------------------------------
  logic [31:0] ctl_word;
  logic [31:0] cap_word;

  // Boundary bit and reserved bits zero
  always_comb
  begin
    ctl_word = 32'h0000_0000;
    ctl_word[PM_CTRL_LSB +: 2] = lctl_r.pm_ctrl;
    ctl_word[RCB_BIT]          = 1'b0;
    ctl_word[LINK_DIS_BIT]     = lctl_r.link_dis;
    ctl_word[RETRAIN_BIT]      = lctl_r.retrain;
    ctl_word[COMMON_CLK_BIT]   = lctl_r.common_clk;
    ctl_word[EXT_SYNC_BIT]     = lctl_r.ext_sync;
    ctl_word[SPEED_LSB +: 4]   = lsts_r.speed;
    ctl_word[WIDTH_LSB +: 6]   = lsts_r.width;
    ctl_word[TRAIN_ERR_BIT]    = lsts_r.train_err;
    ctl_word[TRAINING_BIT]     = lsts_r.training;
    ctl_word[SLOT_CLK_BIT]     = lsts_r.slot_clk;
  end

  always_comb
  begin
    cap_word = 32'h0000_0000;
    cap_word[ATTN_BTN_BIT]   = rev_s && hp_s;
    cap_word[LATCH_SENS_BIT] = rev_s && hp_s;
    cap_word[ATTN_IND_BIT]   = rev_s && hp_s;
    cap_word[PWR_IND_BIT]    = rev_s && hp_s;
    cap_word[HP_CAPABLE_BIT] = rev_s && hp_s;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= 1'b0;
      if (s_axi_arvalid && !s_axi_rvalid && !s_axi_arready)
      begin
        s_axi_arready <= 1'b1;
        s_axi_rvalid  <= 1'b1;
        s_axi_rresp   <= RESP_OKAY;
        if (s_axi_araddr[7:2] == LINK_CTRL_STAT_OFS[7:2])
          s_axi_rdata <= ctl_word;
        else if (s_axi_araddr[7:2] == SLOT_CAP_OFS[7:2])
          s_axi_rdata <= cap_word;
        else
        begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= RESP_SLVERR;
        end
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_pm_reset;
    @(posedge aclk) !aresetn |=> lctl_r.pm_ctrl == PM_CTRL_RST;
  endproperty
  a_pm_reset: assert property (p_pm_reset) else $error("pm field not reset");

  property p_pm_write;
    @(posedge aclk) disable iff (!aresetn)
      ctl_wr |=> ##1 pm_ctrl == $past(wdata_r[1:0], 2);
  endproperty
  a_pm_write: assert property (p_pm_write) else $error("pm output wrong");

  property p_fwd_ro;
    @(posedge aclk) disable iff (!aresetn)
      !rev_s |=> !lctl_r.link_dis && !lctl_r.retrain;
  endproperty
  a_fwd_ro: assert property (p_fwd_ro) else $error("forward mode bit set");

  property p_rev_wr;
    @(posedge aclk) disable iff (!aresetn)
      ctl_wr && rev_s |=> rev_s |-> lctl_r.link_dis == $past(wdata_r[LINK_DIS_BIT]);
  endproperty
  a_rev_wr: assert property (p_rev_wr) else $error("reverse write lost");

  property p_rcb_zero;
    @(posedge aclk) disable iff (!aresetn)
      s_axi_rvalid && !$past(s_axi_rvalid) && $past(s_axi_araddr[7:2]) == 6'h30
        |-> s_axi_rdata[RCB_BIT] == 1'b0 && s_axi_rdata[31:29] == 3'h0;
  endproperty
  a_rcb_zero: assert property (p_rcb_zero) else $error("bit 3 not zero");

  property p_width_valid;
    @(posedge aclk) disable iff (!aresetn)
      lsts_r.width != 6'h00 && lsts_r.speed != 4'h0;
  endproperty
  a_width_valid: assert property (p_width_valid) else $error("bad link status");

  property p_cap_strap;
    @(posedge aclk) disable iff (!aresetn)
      s_axi_arvalid && !s_axi_rvalid && !s_axi_arready && s_axi_araddr[7:2] == 6'h31
        |=> s_axi_rdata[6:0] == ($past(rev_s && hp_s) ? 7'h5D : 7'h00);
  endproperty
  a_cap_strap: assert property (p_cap_strap) else $error("slot cap wrong");

  property p_cap_rsvd;
    @(posedge aclk) disable iff (!aresetn)
      cap_word[31:7] == 25'h0 && cap_word[5] == 1'b0 && cap_word[1] == 1'b0;
  endproperty
  a_cap_rsvd: assert property (p_cap_rsvd) else $error("cap reserved set");

endmodule

// *** verif/tb_plsc_regs.sv ***
// Self-checking bench for the link control, status and slot capability registers.
// Assumes the register block alone, driven over AXI4-Lite on one 20 MHz clock.
`timescale 1ns/1ns
module tb_plsc_regs
  import plsc_pkg::*;
  ;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic        aclk, aresetn;
  logic [7:0]  awaddr, araddr;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic [31:0] wdata, rdata, rd;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, rs;
  logic        arvalid, arready, rvalid, rready;
  logic        rev, strap, terr, trn;
  logic [3:0]  spd;
  logic [5:0]  wid;
  logic [1:0]  pm;
  logic        ldis, rtr;
  int          err_count, checks;

  plsc_regs uut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .reverse_mode(rev),
    .hotplug_strap(strap), .link_speed_in(spd), .link_width_in(wid),
    .link_train_err_in(terr), .link_training_in(trn), .pm_ctrl(pm),
    .link_disable(ldis), .retrain_link(rtr));

  initial
  begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      err_count++;
    end
  endtask

  // Payload held until each channel's own ready is sampled
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= s;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (n = 0; n < 100; n++)
    begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    if (n == 100) begin err_count++; give_verdict(); end
    rs = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic axi_read(input logic [7:0] a);
    int n;
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (n = 0; n < 100; n++)
    begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    if (n == 100) begin err_count++; give_verdict(); end
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask

  // Pins pass a three-stage synchroniser
  task automatic settle();
    repeat (8) @(posedge aclk);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    err_count = 0; checks = 0;
    aresetn = 1'b0; awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0; wstrb = 4'h0;
    awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0; rready = 1'b0;
    rev = 1'b0; strap = 1'b1; spd = 4'h1; wid = 6'h01; terr = 1'b0; trn = 1'b0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    settle();

    axi_read(LINK_CTRL_STAT_OFS);
    check("reset c0", rd, 32'h1011_0000);
    check("reset outs", {28'h0, pm, ldis, rtr}, 32'h0);
    $display("Test reset done");

    for (int i = 0; i < 4; i++)
    begin
      axi_write(LINK_CTRL_STAT_OFS, i, 4'h1);
      axi_read(LINK_CTRL_STAT_OFS);
      check("pm code", rd[15:0], i);
      check("pm out", pm, i);
    end
    // Forward mode keeps bits 4 and 5 at zero
    axi_write(LINK_CTRL_STAT_OFS, 32'hFFFF_FFFF, 4'hF);
    axi_read(LINK_CTRL_STAT_OFS);
    check("fwd all ones", rd, 32'h1011_00C3);
    check("fwd outs", {ldis, rtr}, 32'h0);
    $display("Test forward done");

    rev <= 1'b1;
    settle();
    axi_write(LINK_CTRL_STAT_OFS, 32'h0000_003F, 4'h1);
    axi_read(LINK_CTRL_STAT_OFS);
    check("rev write", rd[15:0], 32'h0033);
    check("rev outs", {pm, ldis, rtr}, 32'hF);
    axi_write(LINK_CTRL_STAT_OFS, 32'h0, 4'h0);
    axi_read(LINK_CTRL_STAT_OFS);
    check("no strobe", rd[15:0], 32'h0033);
    rev <= 1'b0;
    settle();
    axi_read(LINK_CTRL_STAT_OFS);
    check("back fwd", rd[15:0], 32'h0003);
    $display("Test reverse done");

    for (int i = 0; i < 4; i++)
    begin
      rev   <= i[1];
      strap <= i[0];
      settle();
      axi_write(SLOT_CAP_OFS, 32'hFFFF_FFFF, 4'hF);
      check("slot wr resp", rs, RESP_OKAY);
      axi_read(SLOT_CAP_OFS);
      check("slot cap", rd, (i == 3) ? 32'h0000_005D : 32'h0);
    end
    $display("Test slot capability done");

    spd <= 4'h1; wid <= 6'h0C; terr <= 1'b1; trn <= 1'b1;
    settle();
    axi_read(LINK_CTRL_STAT_OFS);
    check("status x12", rd[31:16], 32'h1CC1);
    check("rd resp", rs, RESP_OKAY);
    $display("Test status done");

    axi_read(8'h10);
    check("unmapped data", rd, 32'h0);
    check("unmapped rresp", rs, RESP_SLVERR);
    axi_write(8'h10, 32'hFFFF_FFFF, 4'hF);
    check("unmapped bresp", rs, RESP_SLVERR);
    axi_read(LINK_CTRL_STAT_OFS);
    check("ctrl kept", rd[15:0], 32'h0003);
    $display("Test unmapped done");
    give_verdict();
  end
endmodule
